// *** ebi_pkg.sv ***
// Package: register map, field layout and bus types of the external bus block
package ebi_pkg;

    localparam logic [11:0] ADDR_TIMING_LOW  = 12'h468;
    localparam logic [11:0] ADDR_TIMING_HIGH = 12'h469;
    localparam logic [11:0] ADDR_BUS_CONFIG  = 12'h46a;

    localparam logic [7:0] RESET_TIMING_LOW  = 8'hef;
    localparam logic [7:0] RESET_TIMING_HIGH = 8'hff;
    // Reset value of the configuration register: wait on, bus on, size 0
    localparam logic [7:0] RESET_BUS_CONFIG  = 8'h00;
    localparam logic [7:0] BUS_CONFIG_MASK   = 8'h1f;
    localparam logic [7:0] TIMING_LOW_MASK   = 8'hef;

    localparam int WAIT_DISABLE_BIT = 4;
    localparam int BUS_DISABLE_BIT  = 3;
    localparam int BUS_SIZE_LSB     = 0;
    localparam int LATCH_WIDTH_BIT  = 5;

    // Two-bit field positions (low bit) in the high timing register
    localparam int WRITE_LEN_LSB       = 6;
    localparam int WRITE_LATCH_LEN_LSB = 4;
    localparam int READ_LEN_LSB        = 2;
    localparam int READ_LATCH_LEN_LSB  = 0;
    // Two-bit field positions (low bit) in the low timing register
    localparam int WRITE_MODE_LSB      = 6;
    localparam int CODE_LEN_LSB        = 2;
    localparam int CODE_LATCH_LEN_LSB  = 0;

    // Extra cycles added to a field so a zero field still gives one cycle
    localparam logic [2:0] PHASE_BASE = 3'h1;

    typedef enum logic [1:0] {
        ACC_CODE,
        ACC_READ,
        ACC_WRITE
    } ebi_kind_type;

    typedef struct packed {
        logic         valid;
        ebi_kind_type kind;
        logic         latch;
        logic [19:0]  addr;
        logic [15:0]  wdata;
    } ebi_req_type;

endpackage : ebi_pkg

// *** ebi_top.sv ***
// External bus interface: straps, timing registers and bus cycle sequencer
// Behaviour
// - Program fetch strobe is driven low during every external code fetch.
// - Program fetch strobe stays high except during external code accesses.
// - Code-source select is captured when reset releases and held afterwards.
// - Latched select zero sends every fetch to external memory.
// - Latched select one fetches internally below on-chip size, else external.
// - After capture the same pin acts as the bus wait request.
// - Wait held high stretches any external access until it drops.
// - High timing register holds four two-bit length fields, resets to ff.
// - Low timing register holds mode, latch width, code fields, resets to ef.
// - Bus width strap captured at reset release; zero eight bit, one 16.
// - Address latch strobe pulses high only for real external bus cycles.
// - Separate low-byte write and data read strobes for external data.
`timescale 1ns/1ps
module ebi_top #(
    parameter int ADDR_WIDTH    = 20,
    parameter int ONCHIP_BYTES  = 32768
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                code_source_select,
    input  wire logic                bus_width_strap,
    input  wire logic                reg_write,
    input  wire logic [11:0]         reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire ebi_pkg::ebi_req_type req,
    output logic                     req_ready,
    output logic                     internal_fetch,
    output logic                     done,
    output logic      [15:0]         rdata,
    input  wire logic [15:0]         bus_in,
    output logic      [15:0]         bus_out,
    output logic                     bus_oe_n,
    output logic      [ADDR_WIDTH-1:0] addr_out,
    output logic                     address_latch_strobe,
    output logic                     program_fetch_strobe_n,
    output logic                     read_strobe_n,
    output logic                     low_byte_write_strobe,
    output logic                     high_byte_write_strobe,
    output logic                     wide_bus,
    output logic                     code_external_only
);

    if (ADDR_WIDTH < 16 || ADDR_WIDTH > 20 || ONCHIP_BYTES < 1)
    begin : g_bad_param
        $error("ebi_top: unsupported parameter value");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LATCH,
        ST_DATA,
        ST_END
    } ebi_state_type;

    ebi_state_type state;
    logic [7:0]    timing_low;
    logic [7:0]    timing_high;
    logic [7:0]    bus_config;
    logic          in_reset;
    logic [2:0]    count;
    ebi_pkg::ebi_kind_type kind;
    logic          wait_enable;

    // Register decode
    wire sel_low  = reg_addr == ebi_pkg::ADDR_TIMING_LOW;
    wire sel_high = reg_addr == ebi_pkg::ADDR_TIMING_HIGH;
    wire sel_cfg  = reg_addr == ebi_pkg::ADDR_BUS_CONFIG;
    wire [7:0] next_rdata = sel_low  ? timing_low :
                            sel_high ? timing_high :
                            sel_cfg  ? bus_config : 8'h00;

    // Internal fetch decision from the latched select
    wire below_onchip = 32'(req.addr[ADDR_WIDTH-1:0]) < ONCHIP_BYTES;
    wire go_internal  = req.kind == ebi_pkg::ACC_CODE &&
                        !code_external_only && below_onchip;
    wire bus_off      = bus_config[ebi_pkg::BUS_DISABLE_BIT];
    wire start        = state == ST_IDLE && req.valid && !in_reset;

    // Phase lengths from timing fields
    wire [1:0] latch_field =
        req.kind == ebi_pkg::ACC_CODE ?
            timing_low[ebi_pkg::CODE_LATCH_LEN_LSB +: 2] :
        req.kind == ebi_pkg::ACC_READ ?
            timing_high[ebi_pkg::READ_LATCH_LEN_LSB +: 2] :
            timing_high[ebi_pkg::WRITE_LATCH_LEN_LSB +: 2];
    // Data phase reads the kind held since start, not the live request
    wire [1:0] data_field =
        kind == ebi_pkg::ACC_CODE ?
            timing_low[ebi_pkg::CODE_LEN_LSB +: 2] :
        kind == ebi_pkg::ACC_READ ?
            timing_high[ebi_pkg::READ_LEN_LSB +: 2] :
            timing_high[ebi_pkg::WRITE_LEN_LSB +: 2];
    wire [2:0] latch_len = ebi_pkg::PHASE_BASE + {1'b0, latch_field}
                           + {2'b00, timing_low[ebi_pkg::LATCH_WIDTH_BIT]};
    wire [2:0] data_len  = ebi_pkg::PHASE_BASE + {1'b0, data_field};
    // Wait is the select pin once the strap has been taken
    wire wait_req = wait_enable && code_source_select;
    wire data_last = count == 3'h1 && !wait_req;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            timing_low  <= ebi_pkg::RESET_TIMING_LOW;
            timing_high <= ebi_pkg::RESET_TIMING_HIGH;
            bus_config  <= ebi_pkg::RESET_BUS_CONFIG;
            reg_rdata   <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
            if (reg_write && sel_low)
                timing_low <= reg_wdata & ebi_pkg::TIMING_LOW_MASK;
            if (reg_write && sel_high)
                timing_high <= reg_wdata;
            if (reg_write && sel_cfg)
                bus_config <= reg_wdata & ebi_pkg::BUS_CONFIG_MASK;
        end
    end

    // Straps sampled on the first clock after reset releases
    always_ff @(posedge clock)
    begin
        if (rst)
            in_reset <= 1'b1;
        else
            in_reset <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (in_reset && !rst)
        begin
            code_external_only <= !code_source_select;
            wide_bus           <= bus_width_strap;
        end
    end

    // Cycle sequencer; kind, wait enable and latch length are frozen at start, data length when the latch phase ends
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state                  <= ST_IDLE;
            count                  <= 3'h0;
            kind                   <= ebi_pkg::ACC_CODE;
            wait_enable            <= 1'b0;
            req_ready              <= 1'b0;
            internal_fetch         <= 1'b0;
            done                   <= 1'b0;
            rdata                  <= 16'h0000;
            bus_out                <= 16'h0000;
            bus_oe_n               <= 1'b1;
            addr_out               <= '0;
            address_latch_strobe   <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
            read_strobe_n          <= 1'b1;
            low_byte_write_strobe  <= 1'b0;
            high_byte_write_strobe <= 1'b0;
        end
        else
        begin
            done           <= 1'b0;
            internal_fetch <= 1'b0;
            req_ready      <= state == ST_IDLE && !in_reset && !req.valid;
            unique case (state)
                ST_IDLE:
                begin
                    if (start && (go_internal || bus_off))
                    begin
                        internal_fetch <= go_internal;
                        done           <= 1'b1;
                        // Idle gap so a still-held request is not retaken
                        state          <= ST_END;
                    end
                    else if (start)
                    begin
                        kind        <= req.kind;
                        wait_enable <= !bus_config[ebi_pkg::WAIT_DISABLE_BIT];
                        addr_out    <= req.addr[ADDR_WIDTH-1:0];
                        bus_out     <= req.wdata;
                        bus_oe_n    <= 1'b0;
                        count       <= latch_len;
                        address_latch_strobe <= 1'b1;
                        state       <= ST_LATCH;
                    end
                end
                ST_LATCH:
                begin
                    if (count == 3'h1)
                    begin
                        address_latch_strobe <= 1'b0;
                        count <= data_len;
                        bus_oe_n <= kind != ebi_pkg::ACC_WRITE;
                        program_fetch_strobe_n <=
                            kind != ebi_pkg::ACC_CODE;
                        read_strobe_n <= kind != ebi_pkg::ACC_READ;
                        low_byte_write_strobe <=
                            kind == ebi_pkg::ACC_WRITE;
                        high_byte_write_strobe <=
                            kind == ebi_pkg::ACC_WRITE && wide_bus;
                        state <= ST_DATA;
                    end
                    else
                        count <= count - 3'h1;
                end
                ST_DATA:
                begin
                    if (data_last)
                    begin
                        rdata                  <= bus_in;
                        program_fetch_strobe_n <= 1'b1;
                        read_strobe_n          <= 1'b1;
                        low_byte_write_strobe  <= 1'b0;
                        high_byte_write_strobe <= 1'b0;
                        bus_oe_n               <= 1'b1;
                        done                   <= 1'b1;
                        state                  <= ST_END;
                    end
                    else if (count != 3'h1)
                        count <= count - 3'h1;
                end
                ST_END:
                    state <= ST_IDLE;
            endcase
        end
    end

    property p_strobe_only_code;
        @(posedge clock) disable iff (rst)
        !program_fetch_strobe_n |-> state == ST_DATA && kind == ebi_pkg::ACC_CODE;
    endproperty
    a_strobe_only_code: assert property (p_strobe_only_code)
        else $error("fetch strobe active outside external code cycle");

    property p_fetch_strobe;
        @(posedge clock) disable iff (rst)
        $rose(state == ST_DATA) && kind == ebi_pkg::ACC_CODE
            |-> !program_fetch_strobe_n;
    endproperty
    a_fetch_strobe: assert property (p_fetch_strobe)
        else $error("fetch strobe missing in code cycle");

    property p_internal_no_bus;
        @(posedge clock) disable iff (rst)
        internal_fetch |-> state == ST_END && !address_latch_strobe;
    endproperty
    a_internal_no_bus: assert property (p_internal_no_bus)
        else $error("internal fetch started a bus cycle");

    property p_wait_stretch;
        @(posedge clock) disable iff (rst)
        state == ST_DATA && wait_req |=> state == ST_DATA;
    endproperty
    a_wait_stretch: assert property (p_wait_stretch)
        else $error("access ended while wait was high");

    property p_latch_in_cycle;
        @(posedge clock) disable iff (rst)
        address_latch_strobe |-> state == ST_LATCH;
    endproperty
    a_latch_in_cycle: assert property (p_latch_in_cycle)
        else $error("latch strobe outside address phase");

    property p_reset_high;
        @(posedge clock) $fell(rst) |-> timing_high == 8'hff
            && timing_low == 8'hef;
    endproperty
    a_reset_high: assert property (p_reset_high)
        else $error("timing registers not at reset value");

    property p_strap_hold;
        @(posedge clock) disable iff (rst)
        !in_reset |=> $stable(code_external_only) && $stable(wide_bus);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap value changed after capture");

    property p_strobes_exclusive;
        @(posedge clock) disable iff (rst)
        !(!read_strobe_n && low_byte_write_strobe)
            && !(!read_strobe_n && !program_fetch_strobe_n);
    endproperty
    a_strobes_exclusive: assert property (p_strobes_exclusive)
        else $error("read and write or fetch strobes overlap");

    property p_high_write_wide;
        @(posedge clock) disable iff (rst)
        high_byte_write_strobe |-> wide_bus && low_byte_write_strobe;
    endproperty
    a_high_write_wide: assert property (p_high_write_wide)
        else $error("high byte strobe without wide bus");

    property p_read_releases_bus;
        @(posedge clock) disable iff (rst)
        (!read_strobe_n || !program_fetch_strobe_n) |-> bus_oe_n;
    endproperty
    a_read_releases_bus: assert property (p_read_releases_bus)
        else $error("bus driven while a read strobe is active");

    property p_idle_quiet;
        @(posedge clock) disable iff (rst)
        state == ST_IDLE |-> program_fetch_strobe_n && read_strobe_n
            && !low_byte_write_strobe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("strobe active while sequencer idle");

endmodule : ebi_top

// *** ebi_mem_model.sv ***
// External memory partner: answers fetch and read strobes, drives wait
`timescale 1ns/1ps
module ebi_mem_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        strap,
    input  wire logic [3:0]  wait_len,
    input  wire logic [19:0] addr_out,
    input  wire logic        address_latch_strobe,
    input  wire logic        program_fetch_strobe_n,
    input  wire logic        read_strobe_n,
    output logic      [15:0] bus_in,
    output logic             code_source_select
);
    logic [3:0]  wait_count;
    logic        strap_phase;
    logic [15:0] last;
    wire         reading = !program_fetch_strobe_n || !read_strobe_n;
    // Strap held one edge past release so the capture edge sees it
    assign code_source_select = (rst || strap_phase) ? strap
                              : (wait_count != 4'h0);
    // Released bus shows a changing pattern, not the last word
    assign bus_in = reading ? (addr_out[15:0] ^ 16'h5a5a) : ~last;
    always_ff @(posedge clock)
    begin
        strap_phase <= rst;
        last <= bus_in;
        if (rst)
            wait_count <= 4'h0;
        else if (address_latch_strobe)
            wait_count <= wait_len;
        else if (wait_count != 4'h0)
            wait_count <= wait_count - 4'h1;
    end
endmodule : ebi_mem_model

// *** testbench.sv ***
// Self-checking bench of the external bus block
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rst = 1, strap = 1, bus_width_strap = 1, reg_write = 0;
    logic [11:0] reg_addr = 12'h0;
    logic [7:0] reg_wdata = 8'h0, reg_rdata;
    ebi_pkg::ebi_req_type req = '0;
    logic req_ready, internal_fetch, done, bus_oe_n, address_latch_strobe;
    logic program_fetch_strobe_n, read_strobe_n, low_byte_write_strobe;
    logic high_byte_write_strobe, wide_bus, code_external_only, csel;
    logic [15:0] rdata, bus_in, bus_out;
    logic [19:0] addr_out;
    logic [3:0] wait_len = 4'h0;
    logic [5:0] seen = 6'h0, obs;
    logic [22:0] exp_q[$], ex;
    int bad_count = 0, samples_checked = 0, seed = 32'h6992;
    int lat0, lat3, latw, latd, i;
    ebi_top i_dut (.clock(clock), .rst(rst), .code_source_select(csel),
        .bus_width_strap(bus_width_strap), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .req(req), .req_ready(req_ready), .internal_fetch(internal_fetch),
        .done(done), .rdata(rdata), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n), .addr_out(addr_out),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n),
        .read_strobe_n(read_strobe_n),
        .low_byte_write_strobe(low_byte_write_strobe),
        .high_byte_write_strobe(high_byte_write_strobe),
        .wide_bus(wide_bus), .code_external_only(code_external_only));
    ebi_mem_model i_mem (.clock(clock), .rst(rst), .strap(strap),
        .wait_len(wait_len), .addr_out(addr_out),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n),
        .read_strobe_n(read_strobe_n), .bus_in(bus_in),
        .code_source_select(csel));
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    task automatic check(input string name, input logic [15:0] got,
                         input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic do_reset(input logic cs, input logic bw);
        @(posedge clock);
        rst <= 1'b1;
        strap <= cs;
        bus_width_strap <= bw;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        bus_width_strap <= ~bw;
        @(negedge clock);
        check("wide_bus", 16'(wide_bus), 16'(bw));
        check("ext_only", 16'(code_external_only), 16'(!cs));
    endtask : do_reset
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("reg_rdata", 16'(reg_rdata), 16'(e));
    endtask : rd_reg
    // Flags: fetch, read, low write, high write, latch, internal
    task automatic access(input ebi_pkg::ebi_kind_type k,
                          input logic [19:0] a, input logic [5:0] fl,
                          input logic chk, output int lat);
        int n;
        logic [15:0] w;
        n = 0;
        w = 16'($random(seed));
        exp_q.push_back({fl, chk, a[15:0] ^ 16'h5a5a});
        @(posedge clock);
        req <= '{1'b1, k, 1'b1, a, w};
        do
        begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 300);
        lat = n;
        check("done", 16'(done), 16'h1);
        if (fl[1])
            check("addr_out", addr_out[15:0], a[15:0]);
        if (fl[3])
            check("bus_out", bus_out, w);
        @(posedge clock);
        req.valid <= 1'b0;
        do @(negedge clock); while (req_ready !== 1'b1 && n++ < 300);
        check("req_ready", 16'(req_ready), 16'h1);
    endtask : access
    always @(negedge clock)
    begin
        obs = seen | {!program_fetch_strobe_n, !read_strobe_n,
            low_byte_write_strobe, high_byte_write_strobe,
            address_latch_strobe, internal_fetch};
        seen = (done === 1'b1) ? 6'h0 : obs;
        if (low_byte_write_strobe || !read_strobe_n)
            check("bus_oe_n", 16'(bus_oe_n), 16'(!low_byte_write_strobe));
        if (done === 1'b1)
        begin
            ex = (exp_q.size() > 0) ? exp_q.pop_front() : 23'h7fffff;
            check("strobes", 16'(obs), 16'(ex[22:17]));
            if (ex[16])
                check("rdata", rdata, ex[15:0]);
        end
    end
    initial
    begin
        #50000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        do_reset(1'b1, 1'b1);
        rd_reg(ebi_pkg::ADDR_TIMING_LOW, 8'hef);
        rd_reg(ebi_pkg::ADDR_TIMING_HIGH, 8'hff);
        rd_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h00);
        rd_reg(12'h46b, 8'h00);
        wr_reg(ebi_pkg::ADDR_TIMING_LOW, 8'hff);
        rd_reg(ebi_pkg::ADDR_TIMING_LOW, 8'hef);
        wr_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'hff);
        rd_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h1f);
        wr_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            access(ebi_pkg::ACC_CODE, {5'h0, 15'($random(seed))},
                   6'h01, 1'b0, latd);
            access(ebi_pkg::ACC_CODE, {5'h1, 15'($random(seed))},
                   6'h22, 1'b1, latd);
            access(ebi_pkg::ACC_READ, 20'($random(seed)), 6'h12, 1'b1, lat3);
            access(ebi_pkg::ACC_WRITE, 20'($random(seed)), 6'h0e, 1'b0, latd);
        end
        wr_reg(ebi_pkg::ADDR_TIMING_HIGH, 8'hf3);
        access(ebi_pkg::ACC_READ, 20'h12345, 6'h12, 1'b1, lat0);
        check("field_len", 16'(lat3 - lat0), 16'h3);
        wr_reg(ebi_pkg::ADDR_TIMING_HIGH, 8'hff);
        wait_len <= 4'h6;
        access(ebi_pkg::ACC_READ, 20'h0abcd, 6'h12, 1'b1, latw);
        check("stretched", 16'(latw > lat3), 16'h1);
        check("ext_only", 16'(code_external_only), 16'h0);
        wr_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h10);
        access(ebi_pkg::ACC_READ, 20'h0abcd, 6'h12, 1'b1, latw);
        check("wait_off", 16'(latw), 16'(lat3));
        wait_len <= 4'h0;
        // Disabled bus completes with no strobe and no latch pulse
        wr_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h08);
        access(ebi_pkg::ACC_READ, 20'h00777, 6'h00, 1'b0, latd);
        wr_reg(ebi_pkg::ADDR_BUS_CONFIG, 8'h00);
        do_reset(1'b0, 1'b0);
        access(ebi_pkg::ACC_CODE, 20'h00100, 6'h22, 1'b1, latd);
        access(ebi_pkg::ACC_WRITE, 20'h00200, 6'h0a, 1'b0, latd);
        repeat (4) @(posedge clock);
        report_and_stop();
    end
endmodule : testbench
